// file: include/bspc_pkg.sv
// package: constants and carrier types of the boot strap configuration block
package bspc_pkg;
  // --------------------------------------------------------------
  // strap vector layout
  // --------------------------------------------------------------
  localparam int STRAP_W = 16;
  localparam int MULT_HI = 2;
  localparam int BIT_ENDIAN = 3;
  localparam int BIT_RSV = 4;
  localparam int BIT_DBG_BOOT = 5;
  localparam int WIDTH_LO = 6;
  localparam int WIDTH_HI = 7;
  localparam int BIT_TRACE = 8;
  localparam int BIT_FAST = 9;
  localparam int BIT_DMA = 10;
  localparam int BIT_HOLD_CLK = 11;
  localparam int BIT_TAP_RST = 12;
  localparam int BIT_CPU_DMA = 13;
  localparam int RSV_LO = 14;
  localparam int RSV_HI = 15;
  localparam logic [15:0] STRAP_RST = 16'h0000;

  // --------------------------------------------------------------
  // shared pin positions
  // --------------------------------------------------------------
  localparam int GPIO_W = 32;
  localparam int PIN_BSCAN_RST = 2;
  localparam int PIN_CPU_DMA = 4;
  localparam int PIN_DMA3 = 8;
  localparam int PIN_DMA2 = 9;
  localparam int PIN_DMA1 = 25;
  localparam int PIN_DMA0 = 23;
  localparam int PCST_LO = 10;
  localparam int PCST_HI = 12;
  localparam int PCST_W = 3;
  localparam int PIN_TCLK = 13;
  localparam int PIN_DBG_RST = 31;
  localparam int DMA_W = 4;
  localparam logic [31:0] GPIO_OE_RST = 32'hffff_ffff;

  // --------------------------------------------------------------
  // reset vectors, counts
  // --------------------------------------------------------------
  localparam logic [31:0] VEC_NORMAL = 32'hbfc0_0000;
  localparam logic [31:0] VEC_DEBUG = 32'hff20_0200;
  localparam int RST_CNT_W = 13;
  localparam logic [12:0] RST_LONG_CYC = 13'h1000;
  localparam logic [12:0] RST_FAST_CYC = 13'h0040;
  localparam logic [2:0] CAP_WAIT = 3'h4;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_STRAP = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_TRACE = 0;
  localparam int CTRL_WARM = 1;
  localparam int ST_VALID = 0;
  localparam int ST_RST_BUSY = 1;
  localparam int ST_TRACE = 2;
  localparam int ST_STRAP_ERR = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } bspc_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } bspc_apb_rsp_t;

  typedef struct packed {
    logic [2:0] clk_mult;
    logic big_endian;
    logic [31:0] reset_vector;
    logic [5:0] boot_width;
    logic cfg_valid;
  } bspc_boot_cfg_t;

  // reserved codes decode to zero so software can spot them
  function automatic bspc_boot_cfg_t f_decode(input logic [STRAP_W-1:0] s);
    bspc_boot_cfg_t c;
    c = '0;
    case (s[MULT_HI:0])
      3'h0: c.clk_mult = 3'h2;
      3'h1: c.clk_mult = 3'h3;
      3'h2: c.clk_mult = 3'h4;
      default: c.clk_mult = 3'h0;
    endcase
    c.big_endian = s[BIT_ENDIAN];
    c.reset_vector = s[BIT_DBG_BOOT] ? VEC_DEBUG : VEC_NORMAL;
    case (s[WIDTH_HI:WIDTH_LO])
      2'h0: c.boot_width = 6'h08;
      2'h1: c.boot_width = 6'h10;
      2'h2: c.boot_width = 6'h20;
      default: c.boot_width = 6'h00;
    endcase
    c.cfg_valid = 1'b1;
    return c;
  endfunction : f_decode
endpackage : bspc_pkg

// file: rtl/bspc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module bspc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);
  import bspc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agreed;
  } bspc_sync_st_t;

  bspc_sync_st_t st;
  bspc_sync_st_t next_st;

  // s1 only feeds s2; a bit changes once s2 and s3 agree
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.agreed = (st.s2 & st.s3) | (st.agreed & (st.s2 | st.s3));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.agreed;
endmodule : bspc_sync
`default_nettype wire

// file: rtl/bspc_rst_timer.sv
// reset output pulse timer, normal or fast length
`timescale 1ns/1ns
`default_nettype none
module bspc_rst_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic fast,
  output var logic busy
);
  import bspc_pkg::*;

  typedef struct packed {
    logic [RST_CNT_W-1:0] cnt;
    logic busy;
  } bspc_tmr_st_t;

  bspc_tmr_st_t st;
  bspc_tmr_st_t next_st;

  // busy stands exactly the selected number of cycles, one more than the value loaded into cnt
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.busy = 1'b1;
      next_st.cnt = (fast ? RST_FAST_CYC : RST_LONG_CYC) - 13'h0001;
    end else if (st.busy) begin
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 13'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
endmodule : bspc_rst_timer
`default_nettype wire

// file: rtl/bspc_top.sv
// boot strap capture, pin function select and trace pin reuse
//
// Overview of operation
// RQ1 - strap bits 2:0 pick pipeline multiplier x2, x3, x4; others reserved
// RQ2 - strap bit 3 picks byte order: 0 little, 1 big endian
// RQ3 - strap source keeps bit 4 at zero
// RQ4 - strap bit 5 moves the start address to the debug boot vector
// RQ5 - strap bits 7:6 give boot device width 8, 16, 32; 3 reserved
// RQ6 - strap bit 8 turns pins 31, 13..10 into trace and tap reset pins
// RQ7 - trace pin use beats every other function of those pins
// RQ8 - reset output lasts 4096 cycles, or 64 with fast bit set
// RQ9 - strap bit 10 puts the dma channel indicator on pins 8,9,25,23
// RQ10 - the indicator shows the active channel during each dma transfer
// RQ11 - strap bit 11 holds the system clock output constant
// RQ12 - strap bit 12 makes pin 2 the boundary scan tap reset input
// RQ13 - strap bit 13 drives the cpu versus dma indicator on pin 4
// RQ14 - strap source keeps bits 15 and 14 low
// RQ15 - test data output floats when nothing is shifted out
// RQ16 - in trace mode test data input carries an interrupt ending pc trace
// RQ17 - in trace mode test data output emits the non-sequential pc
// RQ18 - pin 11 stays general io after reset unless trace is strapped
// RQ19 - trace mode drives a trace clock for the probe
// RQ20 - trace clock equals the pipeline clock; here it runs at half of ref_clk
// RQ21 - strap vector is taken as cold reset releases
// RQ22 - captured vector survives warm resets and writes until cold reset
`timescale 1ns/1ns
`default_nettype none
module bspc_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [bspc_pkg::STRAP_W-1:0] memory_data_bus,
  input wire bspc_pkg::bspc_apb_req_t apb_req,
  output var bspc_pkg::bspc_apb_rsp_t apb_rsp,
  output var bspc_pkg::bspc_boot_cfg_t boot_cfg,
  output var logic reset_output_n,
  output var logic system_clock_out,
  input wire logic [bspc_pkg::GPIO_W-1:0] core_gpio_out,
  input wire logic [bspc_pkg::GPIO_W-1:0] core_gpio_oe_n,
  output var logic [bspc_pkg::GPIO_W-1:0] core_gpio_in,
  input wire logic [bspc_pkg::GPIO_W-1:0] general_io_pin_in,
  output var logic [bspc_pkg::GPIO_W-1:0] general_io_pin_out,
  output var logic [bspc_pkg::GPIO_W-1:0] general_io_pin_oe_n,
  input wire logic [bspc_pkg::PCST_W-1:0] trace_status,
  input wire logic trace_pc_bit,
  input wire logic trace_pc_valid,
  output var logic pc_trace_on,
  input wire logic bscan_tdo,
  input wire logic bscan_shift,
  output var logic bscan_tdi,
  input wire logic tdi_in,
  output var logic tdo_out,
  output var logic tdo_oe_n,
  output var logic debug_tap_reset_n,
  output var logic bscan_tap_reset_n,
  input wire logic dma_active,
  input wire logic [bspc_pkg::DMA_W-1:0] dma_channel,
  input wire logic xact_is_dma
);
  import bspc_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [STRAP_W-1:0] cfg;
    bspc_boot_cfg_t bcfg;
    logic [2:0] cap_cnt;
    logic tmr_start;
    logic rst_o;
    logic [RST_CNT_W-1:0] low_cnt;
    logic sysclk;
    logic tclk;
    logic pc_on;
    logic dint_prev;
    logic [GPIO_W-1:0] pin_out;
    logic [GPIO_W-1:0] pin_oe_n;
    logic [GPIO_W-1:0] gpio_in;
    logic tdo;
    logic tdo_oe_n;
    logic tdi;
    logic dbg_rst_n;
    logic bs_rst_n;
    bspc_apb_rsp_t rsp;
  } bspc_top_st_t;

  bspc_top_st_t st;
  bspc_top_st_t next_st;
  logic [STRAP_W-1:0] strap_sync;
  logic [GPIO_W:0] pin_sync;
  logic tmr_busy;
  logic trace;
  logic tdi_sync;
  logic dint_fall;
  logic tpc_emit;
  logic wr_ctrl;
  logic strap_err;
  logic [DMA_W-1:0] dma_ind;

  // --------------------------------------------------------------
  // input synchronisers and reset timer
  // --------------------------------------------------------------
  bspc_sync #(.W(STRAP_W)) u_strap_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in(memory_data_bus),
    .sync_out(strap_sync)
  );

  bspc_sync #(.W(GPIO_W + 1)) u_pin_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({tdi_in, general_io_pin_in}),
    .sync_out(pin_sync)
  );

  bspc_rst_timer u_tmr (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(st.tmr_start),
    .fast(st.cfg[BIT_FAST]),
    .busy(tmr_busy)
  );

  // --------------------------------------------------------------
  // helper terms
  // --------------------------------------------------------------
  assign trace = st.cfg[BIT_TRACE];
  assign tdi_sync = pin_sync[GPIO_W];
  assign dint_fall = trace & st.dint_prev & ~tdi_sync;
  assign tpc_emit = trace & st.pc_on & trace_pc_valid;
  assign dma_ind = dma_active ? dma_channel : '0;
  assign strap_err = st.cfg[BIT_RSV] | (|st.cfg[RSV_HI:RSV_LO]); // RQ3 RQ14
  assign wr_ctrl = apb_req.psel & apb_req.penable & st.rsp.pready &
                   apb_req.pwrite & (apb_req.paddr == REG_CTRL);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] stat;
    stat = '0;
    next_st = st;
    next_st.tmr_start = 1'b0;
    next_st.rsp.pready = 1'b0;

    // strap taken once, a few cycles after cold reset release; only a
    // cold reset clears cfg_valid, so nothing else can retake it
    if (!st.bcfg.cfg_valid) begin
      if (st.cap_cnt == CAP_WAIT) begin
        next_st.cfg = strap_sync; // RQ21 RQ22
        next_st.bcfg = f_decode(strap_sync); // RQ1 RQ2 RQ4 RQ5
        next_st.tmr_start = 1'b1;
      end else begin
        next_st.cap_cnt = st.cap_cnt + 3'h1;
      end
    end

    // warm reset from software reruns the pulse, config untouched
    if (wr_ctrl && apb_req.pwdata[CTRL_WARM] && st.bcfg.cfg_valid &&
        !tmr_busy && !st.tmr_start) begin
      next_st.tmr_start = 1'b1; // RQ22
    end
    next_st.rst_o = st.bcfg.cfg_valid & ~tmr_busy & ~st.tmr_start; // RQ8
    if (st.rst_o || !st.bcfg.cfg_valid) begin
      next_st.low_cnt = '0;
    end else if (!st.tmr_start) begin
      next_st.low_cnt = st.low_cnt + 13'h0001;
    end

    // held low rather than frozen mid-level, so the board sees a quiet net
    next_st.sysclk = st.cfg[BIT_HOLD_CLK] ? 1'b0 : ~st.sysclk; // RQ11
    // no pll here: a trace clock at half of ref_clk, one edge per core cycle, stands in for it
    next_st.tclk = trace ? ~st.tclk : 1'b0; // RQ19 RQ20

    // pc trace: software starts it, probe interrupt stops it and wins
    next_st.dint_prev = tdi_sync;
    if (wr_ctrl && apb_req.pwdata[CTRL_TRACE] && trace) begin
      next_st.pc_on = 1'b1;
    end
    if (dint_fall || !trace) begin
      next_st.pc_on = 1'b0; // RQ16
    end

    // test data out: trace pc first, then boundary scan, else float
    if (tpc_emit) begin
      next_st.tdo = trace_pc_bit; // RQ17
      next_st.tdo_oe_n = 1'b0;
    end else if (bscan_shift) begin
      next_st.tdo = bscan_tdo;
      next_st.tdo_oe_n = 1'b0;
    end else begin
      next_st.tdo = 1'b0;
      next_st.tdo_oe_n = 1'b1; // RQ15
    end
    next_st.tdi = tdi_sync;

    // pin functions; trace is applied last so it overrides the rest
    next_st.gpio_in = pin_sync[GPIO_W-1:0];
    next_st.pin_out = core_gpio_out; // RQ18
    next_st.pin_oe_n = core_gpio_oe_n;
    next_st.bs_rst_n = 1'b1;
    next_st.dbg_rst_n = 1'b1;
    if (st.cfg[BIT_TAP_RST]) begin
      next_st.pin_oe_n[PIN_BSCAN_RST] = 1'b1;
      next_st.bs_rst_n = pin_sync[PIN_BSCAN_RST]; // RQ12
    end
    if (st.cfg[BIT_CPU_DMA]) begin
      next_st.pin_out[PIN_CPU_DMA] = xact_is_dma; // RQ13
      next_st.pin_oe_n[PIN_CPU_DMA] = 1'b0;
    end
    if (st.cfg[BIT_DMA]) begin
      next_st.pin_out[PIN_DMA3] = dma_ind[3]; // RQ9 RQ10
      next_st.pin_out[PIN_DMA2] = dma_ind[2];
      next_st.pin_out[PIN_DMA1] = dma_ind[1];
      next_st.pin_out[PIN_DMA0] = dma_ind[0];
      next_st.pin_oe_n[PIN_DMA3] = 1'b0;
      next_st.pin_oe_n[PIN_DMA2] = 1'b0;
      next_st.pin_oe_n[PIN_DMA1] = 1'b0;
      next_st.pin_oe_n[PIN_DMA0] = 1'b0;
    end
    if (trace) begin
      next_st.pin_out[PCST_HI:PCST_LO] = trace_status; // RQ6 RQ7
      next_st.pin_oe_n[PCST_HI:PCST_LO] = '0;
      next_st.pin_out[PIN_TCLK] = next_st.tclk; // RQ19
      next_st.pin_oe_n[PIN_TCLK] = 1'b0;
      next_st.pin_oe_n[PIN_DBG_RST] = 1'b1;
      next_st.dbg_rst_n = pin_sync[PIN_DBG_RST]; // RQ6
    end

    // apb: answer prepared in setup, pready high for one access cycle
    stat[ST_VALID] = st.bcfg.cfg_valid;
    stat[ST_RST_BUSY] = ~st.rst_o;
    stat[ST_TRACE] = st.pc_on;
    stat[ST_STRAP_ERR] = strap_err;
    if (apb_req.psel && !apb_req.penable) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = '0;
      case (apb_req.paddr)
        REG_STRAP: next_st.rsp.prdata = {16'h0000, st.cfg};
        REG_CTRL: next_st.rsp.prdata = '0;
        REG_STATUS: next_st.rsp.prdata = stat;
        default: next_st.rsp.pslverr = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.cfg <= STRAP_RST;
      st.pin_oe_n <= GPIO_OE_RST;
      st.tdo_oe_n <= 1'b1;
      st.dint_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign boot_cfg = st.bcfg;
  assign reset_output_n = st.rst_o;
  assign system_clock_out = st.sysclk;
  assign core_gpio_in = st.gpio_in;
  assign general_io_pin_out = st.pin_out;
  assign general_io_pin_oe_n = st.pin_oe_n;
  assign pc_trace_on = st.pc_on;
  assign bscan_tdi = st.tdi;
  assign tdo_out = st.tdo;
  assign tdo_oe_n = st.tdo_oe_n;
  assign debug_tap_reset_n = st.dbg_rst_n;
  assign bscan_tap_reset_n = st.bs_rst_n;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_mult; // RQ1
    st.bcfg.cfg_valid |-> (st.cfg[MULT_HI:0] <= 3'h2 ?
      st.bcfg.clk_mult == st.cfg[MULT_HI:0] + 3'h2 : st.bcfg.clk_mult == '0);
  endproperty
  a_mult: assert property (p_mult) else $error("bad clock multiplier");

  property p_endian; // RQ2
    st.bcfg.cfg_valid |-> st.bcfg.big_endian == st.cfg[BIT_ENDIAN];
  endproperty
  a_endian: assert property (p_endian) else $error("bad byte order");

  property p_vec; // RQ4
    st.bcfg.cfg_valid |-> st.bcfg.reset_vector ==
      (st.cfg[BIT_DBG_BOOT] ? 32'hff20_0200 : 32'hbfc0_0000);
  endproperty
  a_vec: assert property (p_vec) else $error("bad reset vector");

  property p_width; // RQ5
    st.bcfg.cfg_valid |-> st.bcfg.boot_width ==
      (&st.cfg[WIDTH_HI:WIDTH_LO] ? 6'h00 : 6'h08 << st.cfg[WIDTH_HI:WIDTH_LO]);
  endproperty
  a_width: assert property (p_width) else $error("bad boot width");

  sequence s_rst_release;
    st.bcfg.cfg_valid ##1 $rose(st.rst_o);
  endsequence
  property p_rst_len; // RQ8
    s_rst_release |-> st.low_cnt ==
      (st.cfg[BIT_FAST] ? 13'h0041 : 13'h1001);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("bad reset length");

  property p_trace_pins; // RQ6
    trace && $past(trace) |-> st.pin_out[PCST_HI:PCST_LO] ==
      $past(trace_status) && st.pin_oe_n[PIN_DBG_RST] &&
      st.pin_out[PIN_TCLK] == st.tclk;
  endproperty
  a_trace_pins: assert property (p_trace_pins) else $error("trace pins");

  // the cycle after reset release shows the reset value, not the core's
  property p_pin11; // RQ18
    $past(reset_n) && !trace && !$past(trace) |->
      st.pin_out[PCST_LO+1] == $past(core_gpio_out[PCST_LO+1]);
  endproperty
  a_pin11: assert property (p_pin11) else $error("pin 11 not gpio");

  property p_dma; // RQ10
    st.cfg[BIT_DMA] && $past(st.cfg[BIT_DMA]) |->
      {st.pin_out[PIN_DMA3], st.pin_out[PIN_DMA2], st.pin_out[PIN_DMA1],
       st.pin_out[PIN_DMA0]} == $past(dma_ind);
  endproperty
  a_dma: assert property (p_dma) else $error("dma indicator wrong");

  property p_hold_clk; // RQ11
    st.cfg[BIT_HOLD_CLK] && $past(st.cfg[BIT_HOLD_CLK]) |-> !st.sysclk;
  endproperty
  a_hold_clk: assert property (p_hold_clk) else $error("clock not held");

  property p_tdo_z; // RQ15
    !bscan_shift && !tpc_emit |=> st.tdo_oe_n;
  endproperty
  a_tdo_z: assert property (p_tdo_z) else $error("tdo driven idle");

  property p_tpc; // RQ17
    tpc_emit |=> !st.tdo_oe_n && st.tdo == $past(trace_pc_bit);
  endproperty
  a_tpc: assert property (p_tpc) else $error("pc bit not on tdo");

  sequence s_dint;
    trace && st.dint_prev && !tdi_sync;
  endsequence
  property p_dint; // RQ16
    s_dint |=> !st.pc_on [*2];
  endproperty
  a_dint: assert property (p_dint) else $error("trace not stopped");

  property p_tclk; // RQ20
    trace && $past(trace) |-> st.tclk != $past(st.tclk);
  endproperty
  a_tclk: assert property (p_tclk) else $error("trace clock stuck");

  property p_strap_hold; // RQ22
    st.bcfg.cfg_valid && $past(st.bcfg.cfg_valid) |-> $stable(st.cfg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_cpu_dma; // RQ13
    st.cfg[BIT_CPU_DMA] && $past(st.cfg[BIT_CPU_DMA]) |->
      st.pin_out[PIN_CPU_DMA] == $past(xact_is_dma) &&
      !st.pin_oe_n[PIN_CPU_DMA];
  endproperty
  a_cpu_dma: assert property (p_cpu_dma) else $error("cpu dma pin wrong");
endmodule : bspc_top
`default_nettype wire

// file: dv/bspc_board_model.sv
// board strap drivers and debug probe
`timescale 1ns/1ns
`default_nettype none
module bspc_board_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] strap,
  input wire logic irq_req,
  output var logic [15:0] memory_data_bus,
  output var logic tdi_in
);
  logic [3:0] hold = 4'h0;
  initial memory_data_bus = 16'h0;
  initial tdi_in = 1'h1;
  // reserved bits held low; once the hold runs out the bus churns
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n || hold < 4'h8) begin
      memory_data_bus <= strap & 16'h3fef;
      hold <= reset_n ? hold + 4'h1 : 4'h0;
    end else begin
      memory_data_bus <= ~memory_data_bus;
    end
  end
  // probe pulls the pulled-up data input low to interrupt
  always @(posedge ref_clk) begin
    tdi_in <= !irq_req;
  end
endmodule : bspc_board_model
`default_nettype wire

// file: dv/test_boot_strap_pin_config.sv
// self-checking bench of the boot strap configuration block
`timescale 1ns/1ns
`default_nettype none
module test_boot_strap_pin_config;
  import bspc_pkg::*;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic irq = 1'h0;
  logic pc_bit = 1'h0, pc_vld = 1'h0, bs_out = 1'h0, bs_sh = 1'h0;
  logic dma_on = 1'h0, is_dma = 1'h0;
  logic [3:0] dma_ch = 4'h0;
  logic [2:0] t_st = 3'h0;
  logic [15:0] strap = 16'h0, mdb;
  logic [31:0] c_out = 32'h0, c_oe_n = 32'h0, ext = 32'h0;
  logic [31:0] p_in, p_out, p_oe_n, rd, c_in;
  logic b_tdi;
  logic tdi, rst_o_n, sclk, pc_on, tdo, tdo_oe_n, dbg_rst_n, bs_rst_n, err;
  bspc_apb_req_t req = '0;
  bspc_apb_rsp_t rsp;
  bspc_boot_cfg_t cfg;
  int miscompares = 0;
  int check_count = 0;
  // pad level: the block where it drives, the board where it lets go
  assign p_in = (p_out & ~p_oe_n) | (ext & p_oe_n);
  initial forever #10 ref_clk = ~ref_clk;
  bspc_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .memory_data_bus(mdb),
    .apb_req(req), .apb_rsp(rsp), .boot_cfg(cfg), .reset_output_n(rst_o_n),
    .system_clock_out(sclk), .core_gpio_out(c_out), .core_gpio_oe_n(c_oe_n),
    .core_gpio_in(c_in), .general_io_pin_in(p_in), .general_io_pin_out(p_out),
    .general_io_pin_oe_n(p_oe_n), .trace_status(t_st), .trace_pc_bit(pc_bit),
    .trace_pc_valid(pc_vld), .pc_trace_on(pc_on), .bscan_tdo(bs_out),
    .bscan_shift(bs_sh), .bscan_tdi(b_tdi), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_n(tdo_oe_n), .debug_tap_reset_n(dbg_rst_n),
    .bscan_tap_reset_n(bs_rst_n), .dma_active(dma_on), .dma_channel(dma_ch),
    .xact_is_dma(is_dma));
  bspc_board_model board (.ref_clk(ref_clk), .reset_n(reset_n),
    .strap(strap), .irq_req(irq), .memory_data_bus(mdb), .tdi_in(tdi));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // apb cycle; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge ref_clk);
    req <= {1'h1, 1'h0, w, a, d};
    @(posedge ref_clk);
    req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'h1 && n < 8);
    if (n >= 8) begin
      chk(1'h0, "apb timeout");
      end_of_test();
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  // wait for the reset output level, counting cycles; a hang ends the run
  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (rst_o_n !== lvl && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      chk(1'h0, "reset output timeout");
      end_of_test();
    end
  endtask : wait_rst
  // cold reset with a strap vector, then pulse length and decode
  task automatic boot(input logic [15:0] s);
    int n;
    int len;
    len = s[9] ? 64 : 4096;
    @(posedge ref_clk);
    strap <= s;
    reset_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    wait_rst(1'h1, n);
    chk(n >= len && n <= len + 10, "reset pulse");
    chk(cfg.cfg_valid === 1'h1 && cfg.big_endian === s[3], "order");
    chk(cfg.reset_vector === (s[5] ? VEC_DEBUG : VEC_NORMAL), "vec");
    apb(1'h0, 8'h00, 32'h0, rd, err);
    chk(rd === {16'h0, s} && err === 1'h0, "captured vector");
  endtask : boot
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // every width code and multiplier codes 0 to 3, reserved 3 included
  task automatic t_decode();
    logic [15:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 16'h0200 | 16'(i) | 16'(i << 6) | 16'(i % 2 * 8) | 16'(i / 2 * 32);
      boot(s);
      chk(cfg.clk_mult === (i < 3 ? 3'(i + 2) : 3'h0), "mult");
      chk(cfg.boot_width === (i < 3 ? 6'h08 << i : 6'h00), "width");
    end
  endtask : t_decode
  // no alternate straps: pins stay general io, scan output floats
  task automatic t_plain();
    logic ck;
    boot(16'h0200);
    c_out <= 32'ha5a5_5a5a;
    c_oe_n <= 32'hffff_0000;
    bs_sh <= 1'h1;
    bs_out <= 1'h1;
    repeat (2) @(posedge ref_clk);
    ck = sclk;
    chk(p_out[15:0] === 16'h5a5a, "gpio out");
    chk(p_oe_n === 32'hffff_0000, "gpio oe");
    chk(bs_rst_n === 1'h1 && dbg_rst_n === 1'h1, "tap idle");
    chk(tdo === 1'h1 && tdo_oe_n === 1'h0, "scan out");
    @(posedge ref_clk);
    chk(sclk !== ck, "clock toggles");
    bs_sh <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk(tdo_oe_n === 1'h1, "tdo floats");
  endtask : t_plain
  // dma, cpu flag, tap reset and held clock strapped together
  task automatic t_alt();
    boot(16'h3e00);
    c_out <= 32'hffff_ffff;
    c_oe_n <= 32'h0;
    dma_on <= 1'h1;
    dma_ch <= 4'h9;
    repeat (2) @(posedge ref_clk);
    chk({p_out[8], p_out[9], p_out[25], p_out[23]} === 4'h9, "ch");
    chk(p_out[4] === 1'h0 && p_oe_n[2] === 1'h1, "cpu, pin 2");
    chk(bs_rst_n === 1'h0 && sclk === 1'h0, "tap low, clk");
    dma_on <= 1'h0;
    is_dma <= 1'h1;
    ext <= 32'h4;
    repeat (8) @(posedge ref_clk);
    chk({p_out[8], p_out[9], p_out[25], p_out[23]} === 4'h0, "idle");
    chk(p_out[4] === 1'h1 && sclk === 1'h0, "cpu, held");
    chk(bs_rst_n === 1'h1 && c_in[2] === 1'h1, "tap follows pin");
  endtask : t_alt
  // trace pins beat the core, pc out on tdo, probe interrupt stops it
  task automatic t_trace();
    logic ck;
    int n;
    boot(16'h0300);
    // core drives pin 31 and lets go of 13:10, so the override shows
    c_oe_n <= 32'h0000_3c00;
    t_st <= 3'h5;
    ext <= 32'h8000_0000;
    repeat (8) @(posedge ref_clk);
    ck = p_out[13];
    chk(p_out[12:10] === 3'h5 && p_oe_n[13:10] === 4'h0, "st");
    chk(p_oe_n[31] === 1'h1 && dbg_rst_n === 1'h1, "probe reset");
    @(posedge ref_clk);
    chk(p_out[13] !== ck, "trace clock");
    apb(1'h1, 8'h04, 32'h1, rd, err);
    pc_vld <= 1'h1;
    pc_bit <= 1'h1;
    repeat (3) @(posedge ref_clk);
    chk(pc_on === 1'h1 && tdo === 1'h1 && tdo_oe_n === 1'h0, "pc");
    chk(b_tdi === 1'h1, "scan input idle high");
    pc_vld <= 1'h0;
    irq <= 1'h1;
    n = 0;
    while (pc_on !== 1'h0 && n < 12) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 12 && b_tdi === 1'h0, "debug interrupt");
    irq <= 1'h0;
  endtask : t_trace
  // full-length boot, then a warm reset leaves the vector alone
  task automatic t_warm();
    int n;
    boot(16'h0000);
    apb(1'h1, 8'h00, 32'hffff, rd, err);
    apb(1'h1, 8'h04, 32'h2, rd, err);
    wait_rst(1'h0, n);
    wait_rst(1'h1, n);
    chk(n >= 4096 && n <= 4106, "warm pulse");
    apb(1'h0, 8'h00, 32'h0, rd, err);
    chk(rd === 32'h0 && cfg.clk_mult === 3'h2, "vector kept");
    apb(1'h0, 8'h08, 32'h0, rd, err);
    chk(rd === 32'h1 && err === 1'h0, "status");
    apb(1'h0, 8'h0c, 32'h0, rd, err);
    chk(err === 1'h1, "unmapped refused");
  endtask : t_warm
  initial begin
    t_decode();
    t_plain();
    t_alt();
    t_trace();
    t_warm();
    end_of_test();
  end
endmodule : test_boot_strap_pin_config
`default_nettype wire
